// >>> hdl/wake_pkg.sv
// constants and types shared by the dormant wakeup controller
// How it works
// (R1) periodic update timer sets dormant length in network saving mode only
// (R2) wakeup timer optional in ultra low power, derived shorter in network mode
// (R3) analog channels wake when sample is above or below a threshold
// (R4) analog channels alternatively wake inside or outside a programmed window
// (R5) wake pins trigger on high, low, rising, falling or either edge
// (R6) reset line with turn-on active resets the device, leaving dormant
// (R7) reset line with turn-on inactive causes emergency power-off
// (R8) turn-on line going inactive to active wakes the device
// (R9) host floats turn-on in network mode; grounded line requests wake
// (R10) dormant stays until an enabled source fires, turn-on is asserted, reset is seen or update timer expires
// (R11) network mode cycles dormant, boot active window, dormant again
// (R12) after becoming active, idle for active-idle time then go dormant in network mode or once go is written
// (R13) new timer values load into the counters at the next idle or dormant entry and are retained across cycles
// (R14) at power-up go active if turn-on asserted, else dormant
// (R15) enabled sources merge into one wake request; config kept across cycles
package wake_pkg;
   localparam logic [7:0] ctrl_addr      = 8'h00;
   localparam logic [7:0] src_en_addr    = 8'h04;
   localparam logic [7:0] pin_cfg_addr   = 8'h08;
   localparam logic [7:0] ana_cfg_addr   = 8'h0c;
   localparam logic [7:0] ana_a_lo_addr  = 8'h10;
   localparam logic [7:0] ana_a_hi_addr  = 8'h14;
   localparam logic [7:0] ana_b_lo_addr  = 8'h18;
   localparam logic [7:0] ana_b_hi_addr  = 8'h1c;
   localparam logic [7:0] update_addr    = 8'h20;
   localparam logic [7:0] idle_addr      = 8'h24;
   localparam logic [7:0] wtimer_addr    = 8'h28;
   localparam logic [7:0] status_addr    = 8'h2c;
   localparam logic [7:0] irq_stat_addr  = 8'h30;
   localparam logic [7:0] irq_mask_addr  = 8'h34;
   localparam logic [7:0] go_addr        = 8'h38;
   // source enable bits
   localparam int en_wtimer = 0;
   localparam int en_ana_a  = 1;
   localparam int en_ana_b  = 2;
   localparam int en_pin_a  = 3;
   localparam int en_pin_b  = 4;
   // margin by which the derived wakeup timer precedes the update timer
   localparam logic [31:0] boot_margin   = 32'h0000_0010;
   localparam logic [1:0]  resp_okay     = 2'h0;
   localparam logic [1:0]  resp_slverr   = 2'h2;
   typedef enum logic [2:0] {
      pin_high, pin_low, pin_rise, pin_fall, pin_both
   } pin_mode_type;
   typedef enum logic [1:0] {
      ana_above, ana_below, ana_inside, ana_outside
   } ana_mode_type;
   typedef enum {st_off, st_active, st_idle, st_dormant} power_state_type;
endpackage

// >>> hdl/dormant_wakeup_controller.sv
// dormant wakeup controller with axi4-lite register slave
//
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module dormant_wakeup_controller #(
   parameter int ana_width = 12
) (
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 rstn,
   // axi4-lite slave
   input  wire logic [7:0]           s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   input  wire logic [7:0]           s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   // host pins, active low, asynchronous
   input  wire logic                 power_on_n,
   input  wire logic                 reset_in_n,
   // wake sensors
   input  wire logic                 pin_wake_a,
   input  wire logic                 pin_wake_b,
   input  wire logic [ana_width-1:0] analog_wake_ch_a,
   input  wire logic [ana_width-1:0] analog_wake_ch_b,
   // power sequencer
   output logic                      wake_request,
   output logic                      device_reset,
   output logic                      emergency_off,
   output logic                      dormant,
   output logic                      irq
);
   logic       rs1, rs2;
   logic [3:0] m1, m2;
   logic [ana_width-1:0] aa1, aa2, ab1, ab2;
   // release reset through two stages
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rs1 <= 1'b0;
         rs2 <= 1'b0;
      end else begin
         rs1 <= 1'b1;
         rs2 <= rs1;
      end
   end
   wire logic rst_n = rs2;
   // two stages, left unreset so the first edge out of reset sees the true turn-on level
   always_ff @(posedge clk) begin
      m1  <= {pin_wake_b, pin_wake_a, reset_in_n, power_on_n};
      m2  <= m1;
      aa1 <= analog_wake_ch_a;
      aa2 <= aa1;
      ab1 <= analog_wake_ch_b;
      ab2 <= ab1;
   end
   wire logic on_now  = ~m2[0];
   wire logic rst_now = ~m2[1];
   // registers
   logic        net_mode, ulp_wtimer_en;
   logic [4:0]  src_en;
   logic [5:0]  pin_cfg;
   logic [3:0]  ana_cfg;
   logic [ana_width-1:0] a_lo, a_hi, b_lo, b_hi;
   logic [31:0] upd_val, idle_val, wt_val;
   logic [4:0]  irq_stat, irq_mask;
   logic        go_dormant;
   logic [3:0]  prev_pins;
   logic        prev_on;

   function automatic logic pin_hit(input logic [2:0] mode, input logic now,
                                    input logic was);
      unique case (wake_pkg::pin_mode_type'(mode))
         wake_pkg::pin_high: pin_hit = now;
         wake_pkg::pin_low:  pin_hit = ~now;
         wake_pkg::pin_rise: pin_hit = now & ~was;
         wake_pkg::pin_fall: pin_hit = ~now & was;
         wake_pkg::pin_both: pin_hit = now ^ was;
         default:            pin_hit = 1'b0;
      endcase
   endfunction
   function automatic logic ana_hit(input logic [1:0] mode,
                                    input logic [ana_width-1:0] v, lo, hi);
      unique case (wake_pkg::ana_mode_type'(mode))
         wake_pkg::ana_above:   ana_hit = v > hi;
         wake_pkg::ana_below:   ana_hit = v < lo;
         wake_pkg::ana_inside:  ana_hit = (v >= lo) && (v <= hi);
         wake_pkg::ana_outside: ana_hit = (v < lo) || (v > hi);
      endcase
   endfunction
   // power state machine
   wake_pkg::power_state_type state, next_state;
   logic [31:0] upd_cnt, next_upd_cnt, wt_cnt, next_wt_cnt, idle_cnt, next_idle_cnt;
   logic        next_wake, next_dev_rst, next_eoff;
   logic [4:0]  ev;
   logic        src_any, upd_exp, wt_exp;
   logic [31:0] wt_eff;
   always_comb begin
      ev[wake_pkg::en_pin_a] = pin_hit(pin_cfg[2:0], m2[2], prev_pins[2]); // [R5]
      ev[wake_pkg::en_pin_b] = pin_hit(pin_cfg[5:3], m2[3], prev_pins[3]); // [R5]
      ev[wake_pkg::en_ana_a] = ana_hit(ana_cfg[1:0], aa2, a_lo, a_hi); // [R3] [R4]
      ev[wake_pkg::en_ana_b] = ana_hit(ana_cfg[3:2], ab2, b_lo, b_hi); // [R3] [R4]
      // derived wakeup precedes the update timer so boot completes in time
      wt_eff = (upd_val > wake_pkg::boot_margin) ? upd_val - wake_pkg::boot_margin
                                                 : 32'h0000_0001; // [R2]
      wt_exp = (wt_cnt == 32'h0000_0000);
      ev[wake_pkg::en_wtimer] = (state == wake_pkg::st_dormant) && wt_exp &&
                                (net_mode || ulp_wtimer_en); // [R2]
      upd_exp = net_mode && (upd_cnt == 32'h0000_0000); // [R1]
      src_any = |(ev & src_en); // [R15]
      next_state    = state;
      next_upd_cnt  = upd_cnt;
      next_wt_cnt   = wt_cnt;
      next_idle_cnt = idle_cnt;
      next_wake     = 1'b0;
      next_dev_rst  = 1'b0;
      next_eoff     = 1'b0;
      unique case (state)
         wake_pkg::st_off: begin
            next_state = on_now ? wake_pkg::st_active : wake_pkg::st_dormant; // [R14]
            next_upd_cnt = upd_val;
            next_wt_cnt  = net_mode ? wt_eff : wt_val;
         end
         wake_pkg::st_active: begin
            next_idle_cnt = idle_val;
            next_state    = wake_pkg::st_idle;
         end
         wake_pkg::st_idle: begin
            if (idle_cnt != 32'h0000_0000) next_idle_cnt = idle_cnt - 32'h0000_0001;
            if (idle_cnt == 32'h0000_0000 && (net_mode || go_dormant)) begin // [R12]
               next_state   = wake_pkg::st_dormant; // [R11]
               next_upd_cnt = upd_val;
               next_wt_cnt  = net_mode ? wt_eff : wt_val;
            end
         end
         wake_pkg::st_dormant: begin
            if (!upd_exp && net_mode) next_upd_cnt = upd_cnt - 32'h0000_0001;
            if (!wt_exp) next_wt_cnt = wt_cnt - 32'h0000_0001;
            // grounded turn-on counts as wake, even if the host should float it
            if (src_any || upd_exp || (on_now && !prev_on) || (on_now && net_mode)) begin
               next_state = wake_pkg::st_active; // [R8] [R9] [R10]
               next_wake  = 1'b1;
            end
         end
      endcase
      if (rst_now) begin
         if (on_now) begin
            next_dev_rst = 1'b1; // [R6]
            next_state   = wake_pkg::st_active;
         end else begin
            next_eoff  = 1'b1; // [R7]
            next_state = wake_pkg::st_off;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state         <= wake_pkg::st_off;
         upd_cnt       <= '0;
         wt_cnt        <= '0;
         idle_cnt      <= '0;
         wake_request  <= 1'b0;
         device_reset  <= 1'b0;
         emergency_off <= 1'b0;
         dormant       <= 1'b0;
         prev_pins     <= 4'hf;
         prev_on       <= 1'b0;
      end else begin
         state         <= next_state;
         upd_cnt       <= next_upd_cnt;
         wt_cnt        <= next_wt_cnt;
         idle_cnt      <= next_idle_cnt;
         wake_request  <= next_wake;
         device_reset  <= next_dev_rst;
         emergency_off <= next_eoff;
         dormant       <= (next_state == wake_pkg::st_dormant);
         prev_pins     <= m2;
         prev_on       <= on_now;
      end
   end

   // axi4-lite slave: one write, one read at a time
   logic        aw_got, w_got;
   logic [7:0]  aw_addr;
   logic [31:0] w_data;
   wire logic   wr_do = aw_got && w_got && !s_axi_bvalid;
   wire logic   rd_do = s_axi_arvalid && s_axi_arready;
   logic [31:0] rd_val;
   logic        rd_ok, wr_ok;
   always_comb begin
      rd_ok = 1'b1;
      unique case (s_axi_araddr)
         wake_pkg::ctrl_addr:     rd_val = {30'h0, ulp_wtimer_en, net_mode};
         wake_pkg::src_en_addr:   rd_val = {27'h0, src_en};
         wake_pkg::pin_cfg_addr:  rd_val = {26'h0, pin_cfg};
         wake_pkg::ana_cfg_addr:  rd_val = {28'h0, ana_cfg};
         wake_pkg::ana_a_lo_addr: rd_val = 32'(a_lo);
         wake_pkg::ana_a_hi_addr: rd_val = 32'(a_hi);
         wake_pkg::ana_b_lo_addr: rd_val = 32'(b_lo);
         wake_pkg::ana_b_hi_addr: rd_val = 32'(b_hi);
         wake_pkg::update_addr:   rd_val = upd_val;
         wake_pkg::idle_addr:     rd_val = idle_val;
         wake_pkg::wtimer_addr:   rd_val = wt_val;
         wake_pkg::status_addr:   rd_val = {25'h0, ev, state == wake_pkg::st_dormant, net_mode};
         wake_pkg::irq_stat_addr: rd_val = {27'h0, irq_stat};
         wake_pkg::irq_mask_addr: rd_val = {27'h0, irq_mask};
         default: begin
            rd_val = 32'h0000_0000;
            rd_ok  = 1'b0;
         end
      endcase
      wr_ok = (aw_addr <= wake_pkg::go_addr) && (aw_addr[1:0] == 2'h0) &&
              (aw_addr != wake_pkg::status_addr) && (aw_addr != wake_pkg::irq_stat_addr);
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_got <= 1'b0;
         w_got  <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= wake_pkg::resp_okay;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= wake_pkg::resp_okay;
         net_mode <= 1'b0;
         ulp_wtimer_en <= 1'b0;
         src_en <= '0;
         pin_cfg <= '0;
         ana_cfg <= '0;
         a_lo <= '0;
         a_hi <= '0;
         b_lo <= '0;
         b_hi <= '0;
         upd_val <= '0;
         idle_val <= '0;
         wt_val <= '0;
         irq_stat <= '0;
         irq_mask <= '0;
         go_dormant <= 1'b0;
         irq <= 1'b0;
      end else begin
         s_axi_awready <= !aw_got && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !w_got && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got  <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got  <= 1'b1;
            w_data <= s_axi_wdata;
         end
         if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
         go_dormant <= go_dormant && (state != wake_pkg::st_dormant);
         if (wr_do) begin
            aw_got <= 1'b0;
            w_got  <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? wake_pkg::resp_okay : wake_pkg::resp_slverr;
            // new values are stored at once, timers load at the next idle or dormant entry; all but go_dormant, cleared at dormant entry, are kept across cycles
            unique case (aw_addr)
               wake_pkg::ctrl_addr:     {ulp_wtimer_en, net_mode} <= w_data[1:0];
               wake_pkg::src_en_addr:   src_en   <= w_data[4:0]; // [R15]
               wake_pkg::pin_cfg_addr:  pin_cfg  <= w_data[5:0];
               wake_pkg::ana_cfg_addr:  ana_cfg  <= w_data[3:0];
               wake_pkg::ana_a_lo_addr: a_lo <= w_data[ana_width-1:0];
               wake_pkg::ana_a_hi_addr: a_hi <= w_data[ana_width-1:0];
               wake_pkg::ana_b_lo_addr: b_lo <= w_data[ana_width-1:0];
               wake_pkg::ana_b_hi_addr: b_hi <= w_data[ana_width-1:0];
               wake_pkg::update_addr:   upd_val  <= w_data; // [R13]
               wake_pkg::idle_addr:     idle_val <= w_data; // [R13]
               wake_pkg::wtimer_addr:   wt_val   <= w_data;
               wake_pkg::irq_mask_addr: irq_mask <= w_data[4:0];
               wake_pkg::go_addr:       go_dormant <= w_data[0];
               default: ;
            endcase
         end
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (rd_do) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_val;
            s_axi_rresp  <= rd_ok ? wake_pkg::resp_okay : wake_pkg::resp_slverr;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
         // event set wins over read clear
         irq_stat <= ((rd_do && s_axi_araddr == wake_pkg::irq_stat_addr) ? 5'h0 : irq_stat)
                     | (next_wake ? (ev & src_en) : 5'h0);
         irq <= |(irq_stat & irq_mask);
      end
   end

   a_eoff_on_rst: assert property (@(posedge clk) disable iff (!rst_n) // [R7]
      (rst_now && !on_now) |=> emergency_off && state == wake_pkg::st_off)
      else $error("emergency off missing");
   a_reset_on: assert property (@(posedge clk) disable iff (!rst_n) // [R6]
      (rst_now && on_now) |=> device_reset && state == wake_pkg::st_active)
      else $error("device reset missing");
   a_turn_on_wake: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
      (state == wake_pkg::st_dormant && on_now && !prev_on && !rst_now) |=> wake_request)
      else $error("turn-on did not wake");
   a_src_wake: assert property (@(posedge clk) disable iff (!rst_n) // [R15]
      (state == wake_pkg::st_dormant && src_any && !rst_now) |=> state == wake_pkg::st_active)
      else $error("enabled source did not wake");
   a_stay_dormant: assert property (@(posedge clk) disable iff (!rst_n) // [R10]
      (state == wake_pkg::st_dormant && !src_any && !upd_exp && !on_now && !rst_now)
      |=> state == wake_pkg::st_dormant)
      else $error("left dormant without cause");
   a_upd_expire: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
      (state == wake_pkg::st_dormant && upd_exp && !rst_now) |=> wake_request)
      else $error("update timer expiry ignored");
   a_idle_hold: assert property (@(posedge clk) disable iff (!rst_n) // [R12]
      (state == wake_pkg::st_idle && idle_cnt != 0 && !rst_now) |=> state == wake_pkg::st_idle)
      else $error("left idle early");
   a_power_up: assert property (@(posedge clk) disable iff (!rst_n) // [R14]
      (state == wake_pkg::st_off && !rst_now) |=>
      state == ($past(on_now) ? wake_pkg::st_active : wake_pkg::st_dormant))
      else $error("wrong power-up state");
   c_net_cycle: cover property (@(posedge clk) disable iff (!rst_n)
      net_mode && state == wake_pkg::st_idle ##1 state == wake_pkg::st_dormant);
   c_pin_wake: cover property (@(posedge clk) disable iff (!rst_n)
      wake_request && irq_stat[wake_pkg::en_pin_a]);
   c_eoff: cover property (@(posedge clk) disable iff (!rst_n) emergency_off);
endmodule
`default_nettype wire

// >>> test/host_board.sv
// host board model driving turn-on, reset, wake pins and analog inputs
`timescale 1ns/1ps
`default_nettype none
module host_board #(
   parameter int ana_width = 12
) (
   // clock
   input  wire logic                 clk,
   // lines into the device
   output logic                      power_on_n,
   output logic                      reset_in_n,
   output logic                      pin_a,
   output logic                      pin_b,
   output logic [ana_width-1:0]      ana_a,
   output logic [ana_width-1:0]      ana_b
);
   // turn-on is left floating, so its pull-up holds it high
   initial begin
      power_on_n = 1'b1;
      reset_in_n = 1'b1;
      pin_a = 1'b0;
      pin_b = 1'b0;
      ana_a = '0;
      ana_b = '0;
   end
   // grounding turn-on is how the host asks for a wake
   task automatic drive_power(input logic v);
      @(posedge clk);
      power_on_n <= v;
   endtask
   // reset pulse; its meaning depends on the turn-on level
   task automatic drive_reset(input logic v);
      @(posedge clk);
      reset_in_n <= v;
   endtask
   task automatic drive_pins(input logic a, input logic b);
      @(posedge clk);
      pin_a <= a;
      pin_b <= b;
   endtask
   task automatic drive_analog(input logic [ana_width-1:0] a, input logic [ana_width-1:0] b);
      @(posedge clk);
      ana_a <= a;
      ana_b <= b;
   endtask
endmodule
`default_nettype wire

// >>> test/dormant_wakeup_controller_tb.sv
// self-checking bench for the dormant wakeup controller
`timescale 1ns/1ps
`default_nettype none
module dormant_wakeup_controller_tb;
   logic        clk;
   logic        rstn;
   logic [7:0]  awaddr;
   logic        awvalid;
   logic [31:0] wdata;
   logic        wvalid;
   logic        bready;
   logic [7:0]  araddr;
   logic        arvalid;
   logic        rready;
   wire logic   awready, wready, bvalid, arready, rvalid;
   wire logic   [1:0] bresp, rresp;
   wire logic   [31:0] rdata;
   wire logic   power_on_n, reset_in_n, pin_a, pin_b;
   wire logic   [11:0] ana_a, ana_b;
   wire logic   wake_request, device_reset, emergency_off, dormant, irq;
   int          num_errors, total_checks, cycles, wakes, resets_seen, offs_seen;

   dormant_wakeup_controller #(.ana_width(12)) DUT (
      .clk(clk), .rstn(rstn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .power_on_n(power_on_n), .reset_in_n(reset_in_n),
      .pin_wake_a(pin_a), .pin_wake_b(pin_b),
      .analog_wake_ch_a(ana_a), .analog_wake_ch_b(ana_b),
      .wake_request(wake_request), .device_reset(device_reset),
      .emergency_off(emergency_off), .dormant(dormant), .irq(irq));

   host_board #(.ana_width(12)) host (
      .clk(clk), .power_on_n(power_on_n), .reset_in_n(reset_in_n),
      .pin_a(pin_a), .pin_b(pin_b), .ana_a(ana_a), .ana_b(ana_b));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // a wake is a one-cycle pulse, so it is counted rather than polled
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (wake_request === 1'b1) wakes <= wakes + 1;
      if (device_reset === 1'b1) resets_seen <= resets_seen + 1;
      if (emergency_off === 1'b1) offs_seen <= offs_seen + 1;
      if (cycles == 20000) begin
         num_errors = num_errors + 1;
         final_report();
      end
   end

   task automatic final_report;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks = total_checks + 1;
      if (seen !== exp) begin
         num_errors = num_errors + 1;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_done, w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge clk);
         if (!aw_done && awready === 1'b1) begin
            aw_done = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_done && wready === 1'b1) begin
            w_done = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge clk); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask

   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      axi_write(a, d, r);
   endtask

   task automatic expect_wake(input string name, input int n, input logic exp);
      int start;
      start = wakes;
      for (int i = 0; i < n && wakes == start; i++) @(posedge clk);
      check(name, 32'(wakes != start), 32'(exp));
   endtask

   task automatic wait_dormant(input int n);
      for (int i = 0; i < n && dormant !== 1'b1; i++) @(posedge clk);
      check("dormant", 32'(dormant), 32'h1);
   endtask

   task automatic go_dormant;
      wr(wake_pkg::go_addr, 32'h1);
      wait_dormant(20);
   endtask

   // nothing enabled: stimulus on every sensor must not wake, turn-on still does
   task automatic t_disabled;
      host.drive_pins(1'b1, 1'b1);
      host.drive_analog(12'hfff, 12'hfff);
      expect_wake("disabled sources", 20, 1'b0);
      check("still dormant", 32'(dormant), 32'h1);
      host.drive_power(1'b0);
      expect_wake("turn-on wake", 12, 1'b1);
      check("left dormant", 32'(dormant), 32'h0);
      host.drive_power(1'b1);
   endtask

   // every pin mode: idle at the quiet level, then move to the trigger level
   task automatic t_pins;
      logic pre;
      wr(wake_pkg::src_en_addr, 32'h08);
      for (int m = 0; m < 5; m++) begin
         pre = (m == 1 || m == 3);
         host.drive_pins(pre, 1'b0);
         wr(wake_pkg::pin_cfg_addr, 32'(m));
         go_dormant();
         expect_wake("pin quiet", 8, 1'b0);
         host.drive_pins(!pre, 1'b0);
         expect_wake("pin wake", 12, 1'b1);
      end
   endtask

   // window 100..200 on each channel in turn, every threshold and range mode
   task automatic t_analog;
      logic [11:0] pre, post;
      for (int c = 0; c < 2; c++) begin
         wr(wake_pkg::src_en_addr, (c == 0) ? 32'h02 : 32'h04);
         wr((c == 0) ? wake_pkg::ana_a_lo_addr : wake_pkg::ana_b_lo_addr, 32'd100);
         wr((c == 0) ? wake_pkg::ana_a_hi_addr : wake_pkg::ana_b_hi_addr, 32'd200);
         for (int m = 0; m < 4; m++) begin
            pre = (m == 2) ? 12'd50 : 12'd150;
            post = (m == 1) ? 12'd50 : (m == 2) ? 12'd150 : 12'd250;
            host.drive_analog(pre, pre);
            wr(wake_pkg::ana_cfg_addr, 32'(m << (2 * c)));
            go_dormant();
            expect_wake("analog quiet", 8, 1'b0);
            host.drive_analog(post, post);
            expect_wake("analog wake", 12, 1'b1);
         end
      end
   endtask

   task automatic t_irq;
      logic [31:0] d;
      logic [1:0]  r;
      wr(wake_pkg::src_en_addr, 32'h10);
      wr(wake_pkg::pin_cfg_addr, 32'h10);
      for (int k = 0; k < 2; k++) begin
         wr(wake_pkg::irq_mask_addr, (k == 0) ? 32'hffff_ffff : 32'h0);
         axi_read(wake_pkg::irq_stat_addr, d, r);
         host.drive_pins(pin_a, 1'b0);
         go_dormant();
         host.drive_pins(pin_a, 1'b1);
         expect_wake("pin b wake", 12, 1'b1);
         repeat (3) @(posedge clk);
         check("irq level", 32'(irq), (k == 0) ? 32'h1 : 32'h0);
         axi_read(wake_pkg::irq_stat_addr, d, r);
         check("irq status set", 32'(d != 0), 32'h1);
         repeat (3) @(posedge clk);
         check("irq cleared", 32'(irq), 32'h0);
         axi_read(wake_pkg::irq_stat_addr, d, r);
         check("irq status clear", d, 32'h0);
      end
   endtask

   task automatic t_bus_err;
      logic [31:0] d;
      logic [1:0]  r;
      axi_read(8'hfc, d, r);
      check("unmapped rresp", 32'(r), 32'(wake_pkg::resp_slverr));
      check("unmapped rdata", d, 32'h0);
      axi_write(wake_pkg::status_addr, 32'h1, r);
      check("read-only bresp", 32'(r), 32'(wake_pkg::resp_slverr));
   endtask

   // network mode: idle, dormant, derived timer wakes 16 cycles before 60
   task automatic t_net;
      logic [31:0] d;
      logic [1:0]  r;
      wr(wake_pkg::update_addr, 32'd60);
      axi_read(wake_pkg::update_addr, d, r);
      check("update timer kept", d, 32'd60);
      wr(wake_pkg::src_en_addr, 32'h01);
      wr(wake_pkg::ctrl_addr, 32'h1);
      wait_dormant(40);
      expect_wake("no early wake", 40, 1'b0);
      expect_wake("derived timer", 12, 1'b1);
      wait_dormant(40);
      wr(wake_pkg::ctrl_addr, 32'h0);
   endtask

   task automatic t_host_reset;
      int start;
      host.drive_power(1'b0);
      repeat (12) @(posedge clk);
      resets_seen = 0;
      offs_seen = 0;
      host.drive_reset(1'b0);
      repeat (8) @(posedge clk);
      host.drive_reset(1'b1);
      repeat (4) @(posedge clk);
      check("device reset", 32'(resets_seen > 0), 32'h1);
      check("no power-off", 32'(offs_seen), 32'h0);
      host.drive_power(1'b1);
      repeat (6) @(posedge clk);
      resets_seen = 0;
      host.drive_reset(1'b0);
      repeat (8) @(posedge clk);
      host.drive_reset(1'b1);
      repeat (4) @(posedge clk);
      check("emergency off", 32'(offs_seen > 0), 32'h1);
      check("no device reset", 32'(resets_seen), 32'h0);
      // power-up with turn-on held low goes straight to active, no wake pulse
      host.drive_power(1'b0);
      rstn <= 1'b0;
      start = wakes;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      repeat (8) @(posedge clk);
      check("power-up active", 32'(dormant), 32'h0);
      check("power-up wake", 32'(wakes - start), 32'h0);
   endtask

   initial begin
      {num_errors, total_checks, cycles, wakes, resets_seen, offs_seen} = '0;
      {rstn, awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      repeat (4) @(posedge clk);
      wait_dormant(10);
      wr(wake_pkg::idle_addr, 32'd4);
      t_disabled();
      t_pins();
      t_analog();
      t_irq();
      t_bus_err();
      t_net();
      t_host_reset();
      final_report();
   end
endmodule
`default_nettype wire
